// ==== shared/radio_cfg_defines.vh ====
`ifndef RADIO_CFG_DEFINES_VH
`define RADIO_CFG_DEFINES_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_TOP_CONFIGURATION 5'h00
`define ADDR_AUTO_ACK_ENABLES 5'h01
`define ADDR_RECEIVE_PIPE_ENABLES 5'h02
`define ADDR_ADDRESS_WIDTH_SETUP 5'h03
`define ADDR_RETRANSMIT_SETUP 5'h04
`define ADDR_CHANNEL_SELECT 5'h05
`define ADDR_RADIO_SETUP 5'h06
`define ADDR_EVENT_FLAGS 5'h07
`define ADDR_TRANSMIT_OBSERVATION 5'h08
`define ADDR_SIGNAL_STRENGTH_CONTROL 5'h09
`define ADDR_PIPE0_RECEIVE_ADDRESS 5'h0A
`define ADDR_PIPE1_RECEIVE_ADDRESS 5'h0B
`define ADDR_PIPE2_RECEIVE_ADDRESS_LOW 5'h0C

// ****************************************
// commands
// ****************************************
`define CMD_READ_REGISTER 3'h0
`define CMD_WRITE_REGISTER 3'h1
`define MAX_DATA_BYTES 3'h5

// ****************************************
// field positions
// ****************************************
`define BIT_RX_READY 6
`define BIT_TX_DONE 5
`define BIT_RETRY_LIMIT 4
`define BIT_CRC_ENABLE 3
`define BIT_CHECKSUM_WIDTH 2
`define BIT_POWER_UP 1
`define BIT_PRIMARY_RECEIVER 0

// ****************************************
// reset values
// ****************************************
`define RESET_TOP_CONFIGURATION 8'h08
`define RESET_PIPE_ENABLES 6'h3F
`define RESET_ADDRESS_WIDTH 4'hF
`define RESET_RETRANSMIT_SETUP 8'h03
`define RESET_CHANNEL 7'h02
`define RESET_TRANSMIT_POWER 2'h1
`define RESET_PIPE_NUMBER 3'h7
`define RESET_PIPE0_ADDRESS 40'hE7_E7E7_E7E7
`define RESET_PIPE1_ADDRESS 40'hC2_C2C2_C2C2
`define RESET_PIPE2_ADDRESS 8'hC3

// ****************************************
// timing
// ****************************************
`define CORE_CLK_MHZ 50
`define RETRY_STEP_US 250
`define RETRY_STEP_CYCLES (`RETRY_STEP_US * `CORE_CLK_MHZ)
`define COUNT_SATURATE 4'hF

`endif

// ==== logic/pin_sync.v ====
`timescale 1ns/100ps
module pin_sync #(
  parameter WIDTH = 3
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage_one;

  // ****************************************
  // two-flop synchroniser
  // ****************************************
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      stage_one <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end
endmodule // pin_sync

// ==== logic/spi_link_slave.v ====
`timescale 1ns/100ps
module spi_link_slave (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_sck,
  input wire i_csn,
  input wire i_mosi,
  input wire [7:0] i_tx_byte,
  output reg o_frame_start,
  output reg o_byte_valid,
  output reg [7:0] o_rx_byte,
  output reg o_miso,
  output reg o_miso_oe
);
  reg sck_q;
  reg csn_q;
  reg [2:0] bit_cnt;
  reg [7:0] rx_shift;
  reg [7:0] tx_shift;
  wire sck_rise;
  wire sck_fall;

  assign sck_rise = i_sck & ~sck_q;
  assign sck_fall = ~i_sck & sck_q;

  // ****************************************
  // shift engine, msb first, mode 0
  // ****************************************
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      sck_q <= 1'b0;
      csn_q <= 1'b1;
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      tx_shift <= 8'h00;
      o_frame_start <= 1'b0;
      o_byte_valid <= 1'b0;
      o_rx_byte <= 8'h00;
      o_miso <= 1'b0;
      o_miso_oe <= 1'b0;
    end else begin
      sck_q <= i_sck;
      csn_q <= i_csn;
      o_frame_start <= 1'b0;
      o_byte_valid <= 1'b0;
      if (i_csn) begin
        bit_cnt <= 3'h0;
        o_miso_oe <= 1'b0;
      end else begin
        o_miso_oe <= 1'b1;
        if (csn_q) begin
          o_frame_start <= 1'b1;
          bit_cnt <= 3'h0;
          tx_shift <= i_tx_byte;
          o_miso <= i_tx_byte[7];
        end else if (sck_rise) begin
          rx_shift <= {rx_shift[6:0], i_mosi};
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            o_byte_valid <= 1'b1;
            o_rx_byte <= {rx_shift[6:0], i_mosi};
          end
        end else if (sck_fall) begin
          if (bit_cnt == 3'h0) begin
            tx_shift <= i_tx_byte;
            o_miso <= i_tx_byte[7];
          end else begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            o_miso <= tx_shift[6];
          end
        end
      end
    end
  end
endmodule // spi_link_slave

// ==== logic/radio_config_register_bank.v ====
`timescale 1ns/100ps
`include "radio_cfg_defines.vh"
module radio_config_register_bank #(
  parameter [17:0] RETRY_STEP_CYCLES = `RETRY_STEP_CYCLES
) (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_csn,
  input wire i_sck,
  input wire i_mosi,
  input wire i_rx_data_arrived,
  input wire [2:0] i_rx_pipe_number,
  input wire i_rx_fifo_empty,
  input wire i_tx_sent,
  input wire i_ack_received,
  input wire i_retry_limit_hit,
  input wire i_tx_fifo_full,
  input wire i_packet_lost,
  input wire i_retransmit,
  input wire i_new_packet_start,
  input wire i_retry_wait_start,
  input wire i_signal_threshold_one,
  input wire i_signal_threshold_two,
  output wire o_miso,
  output wire o_miso_oe,
  output reg o_irq_n,
  output reg o_power_up,
  output reg o_primary_receiver,
  output reg o_crc_enable,
  output reg o_checksum_width_select,
  output reg [5:0] o_pipe_autoack_enable,
  output reg [5:0] o_pipe_receive_enable,
  output reg [3:0] o_retry_limit_code,
  output reg [6:0] o_channel_number,
  output reg o_carrier_test_enable,
  output reg o_pseudo_random_test_enable,
  output reg o_rate_select_low,
  output reg o_rate_select_high,
  output reg o_transmit_attenuate,
  output reg [1:0] o_transmit_power_code,
  output reg o_signal_measure_enable,
  output reg [39:0] o_pipe0_address,
  output reg [39:0] o_pipe1_address,
  output reg [7:0] o_pipe2_address_low,
  output reg o_transmit_hold,
  output reg o_retry_wait_done
);

  // ****************************************
  // decode helpers
  // ****************************************
  function write_hit;
    input stb;
    input [4:0] addr;
    input [4:0] target;
    begin
      write_hit = stb & (addr == target);
    end
  endfunction

  function [7:0] sel_byte;
    input [39:0] word;
    input [2:0] idx;
    begin
      if (idx < `MAX_DATA_BYTES) begin
        sel_byte = word[idx*8 +: 8];
      end else begin
        sel_byte = 8'h00;
      end
    end
  endfunction

  // ****************************************
  // storage
  // ****************************************
  localparam [7:0] RETRY_RESET = `RESET_RETRANSMIT_SETUP;
  localparam [39:0] PIPE0_RESET = `RESET_PIPE0_ADDRESS;
  localparam [39:0] PIPE1_RESET = `RESET_PIPE1_ADDRESS;
  reg top_reserved;
  reg rx_ready_irq_mask;
  reg tx_done_irq_mask;
  reg retry_limit_irq_mask;
  reg crc_enable_bit;
  reg [3:0] address_width_setup;
  reg [3:0] retry_delay_code;
  reg pseudo_random_bit;
  reg [2:0] signal_reserved;
  reg rx_ready_flag;
  reg tx_done_flag;
  reg retry_limit_flag;
  reg [2:0] pipe_number;
  reg [3:0] lost_packet_count;
  reg [3:0] retry_count;
  reg [17:0] retry_timer;
  reg first_byte;
  reg [2:0] cmd_op;
  reg [4:0] cmd_addr;
  reg [2:0] data_cnt;
  reg [7:0] out_byte;
  reg [39:0] rd_word;
  wire [2:0] pins_sync;
  wire frame_start;
  wire byte_valid;
  wire [7:0] rx_byte;
  wire [7:0] status_byte;
  wire [7:0] tx_byte;
  wire crc_effective;
  wire wr_stb;
  wire wr_single;
  wire [4:0] rd_addr;
  wire [2:0] rd_idx;
  wire flag_clear;
  wire [31:0] retry_wait_product;

  // ****************************************
  // link input and shifter
  // ****************************************
  pin_sync #(
    .WIDTH(3)
  ) u_pin_sync (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_async({i_csn, i_sck, i_mosi}),
    .o_sync(pins_sync)
  );

  spi_link_slave u_spi_link_slave (
    .i_core_clk(i_core_clk),
    .i_reset(i_reset),
    .i_sck(pins_sync[1]),
    .i_csn(pins_sync[2]),
    .i_mosi(pins_sync[0]),
    .i_tx_byte(tx_byte),
    .o_frame_start(frame_start),
    .o_byte_valid(byte_valid),
    .o_rx_byte(rx_byte),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe)
  );

  assign status_byte = {1'b0, rx_ready_flag, tx_done_flag, retry_limit_flag,
    pipe_number, i_tx_fifo_full};
  assign tx_byte = first_byte ? status_byte : out_byte;

  // ****************************************
  // command tracking
  // ****************************************
  // command and address capture
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      first_byte <= 1'b1;
      cmd_op <= 3'h7;
      cmd_addr <= 5'h00;
      data_cnt <= 3'h0;
      out_byte <= 8'h00;
    end else begin
      if (frame_start || pins_sync[2]) begin
        first_byte <= 1'b1;
        data_cnt <= 3'h0;
      end else if (byte_valid) begin
        first_byte <= 1'b0;
        out_byte <= 8'h00;
        if (first_byte) begin
          cmd_op <= rx_byte[7:5];
          cmd_addr <= rx_byte[4:0];
        end else if (data_cnt != 3'h7) begin
          data_cnt <= data_cnt + 3'h1;
        end
        if ((first_byte ? rx_byte[7:5] : cmd_op) == `CMD_READ_REGISTER) begin
          out_byte <= sel_byte(rd_word, rd_idx);
        end
      end
    end
  end

  assign rd_addr = first_byte ? rx_byte[4:0] : cmd_addr;
  assign rd_idx = first_byte ? 3'h0 : data_cnt + 3'h1;
  assign wr_stb = byte_valid & ~first_byte & (cmd_op == `CMD_WRITE_REGISTER)
    & (data_cnt < `MAX_DATA_BYTES);
  assign wr_single = wr_stb & (data_cnt == 3'h0);
  assign crc_effective = crc_enable_bit | (|o_pipe_autoack_enable);
  assign flag_clear = write_hit(wr_single, cmd_addr, `ADDR_EVENT_FLAGS);

  // ****************************************
  // read mux
  // ****************************************
  // unmapped reads as zero
  always @* begin
    rd_word = 40'h00_0000_0000;
    if (rd_addr == `ADDR_TOP_CONFIGURATION) begin
      rd_word[7:0] = {top_reserved, rx_ready_irq_mask, tx_done_irq_mask,
        retry_limit_irq_mask, crc_effective, o_checksum_width_select,
        o_power_up, o_primary_receiver};
    end else if (rd_addr == `ADDR_AUTO_ACK_ENABLES) begin
      rd_word[7:0] = {2'b00, o_pipe_autoack_enable};
    end else if (rd_addr == `ADDR_RECEIVE_PIPE_ENABLES) begin
      rd_word[7:0] = {2'b00, o_pipe_receive_enable};
    end else if (rd_addr == `ADDR_ADDRESS_WIDTH_SETUP) begin
      rd_word[7:0] = {4'h0, address_width_setup};
    end else if (rd_addr == `ADDR_RETRANSMIT_SETUP) begin
      rd_word[7:0] = {retry_delay_code, o_retry_limit_code};
    end else if (rd_addr == `ADDR_CHANNEL_SELECT) begin
      rd_word[7:0] = {1'b0, o_channel_number};
    end else if (rd_addr == `ADDR_RADIO_SETUP) begin
      rd_word[7:0] = {o_carrier_test_enable, pseudo_random_bit, o_rate_select_low,
        o_transmit_attenuate, o_rate_select_high, o_transmit_power_code, 1'b0};
    end else if (rd_addr == `ADDR_EVENT_FLAGS) begin
      rd_word[7:0] = status_byte;
    end else if (rd_addr == `ADDR_TRANSMIT_OBSERVATION) begin
      rd_word[7:0] = {lost_packet_count, retry_count};
    end else if (rd_addr == `ADDR_SIGNAL_STRENGTH_CONTROL) begin
      rd_word[7:0] = {signal_reserved, o_signal_measure_enable, 2'b00,
        i_signal_threshold_two, i_signal_threshold_one};
    end else if (rd_addr == `ADDR_PIPE0_RECEIVE_ADDRESS) begin
      rd_word = o_pipe0_address;
    end else if (rd_addr == `ADDR_PIPE1_RECEIVE_ADDRESS) begin
      rd_word = o_pipe1_address;
    end else if (rd_addr == `ADDR_PIPE2_RECEIVE_ADDRESS_LOW) begin
      rd_word[7:0] = o_pipe2_address_low;
    end
  end

  // ****************************************
  // single-byte configuration
  // ****************************************
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      top_reserved <= 1'b0;
      rx_ready_irq_mask <= 1'b0;
      tx_done_irq_mask <= 1'b0;
      retry_limit_irq_mask <= 1'b0;
      crc_enable_bit <= 1'b1;
      o_checksum_width_select <= 1'b0;
      o_power_up <= 1'b0;
      o_primary_receiver <= 1'b0;
      o_pipe_autoack_enable <= `RESET_PIPE_ENABLES;
      o_pipe_receive_enable <= `RESET_PIPE_ENABLES;
      address_width_setup <= `RESET_ADDRESS_WIDTH;
      retry_delay_code <= RETRY_RESET[7:4];
      o_retry_limit_code <= RETRY_RESET[3:0];
      o_channel_number <= `RESET_CHANNEL;
      o_carrier_test_enable <= 1'b0;
      pseudo_random_bit <= 1'b0;
      o_rate_select_low <= 1'b0;
      o_transmit_attenuate <= 1'b0;
      o_rate_select_high <= 1'b0;
      o_transmit_power_code <= `RESET_TRANSMIT_POWER;
      signal_reserved <= 3'h0;
      o_signal_measure_enable <= 1'b0;
      o_pipe2_address_low <= `RESET_PIPE2_ADDRESS;
    end else begin
      if (write_hit(wr_single, cmd_addr, `ADDR_TOP_CONFIGURATION)) begin
        {top_reserved, rx_ready_irq_mask, tx_done_irq_mask, retry_limit_irq_mask,
          crc_enable_bit, o_checksum_width_select, o_power_up,
          o_primary_receiver} <= rx_byte;
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_AUTO_ACK_ENABLES)) begin
        o_pipe_autoack_enable <= rx_byte[5:0];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_RECEIVE_PIPE_ENABLES)) begin
        o_pipe_receive_enable <= rx_byte[5:0];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_ADDRESS_WIDTH_SETUP)) begin
        address_width_setup <= rx_byte[3:0];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_RETRANSMIT_SETUP)) begin
        retry_delay_code <= rx_byte[7:4];
        o_retry_limit_code <= rx_byte[3:0];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_CHANNEL_SELECT)) begin
        o_channel_number <= rx_byte[6:0];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_RADIO_SETUP)) begin
        {o_carrier_test_enable, pseudo_random_bit, o_rate_select_low,
          o_transmit_attenuate, o_rate_select_high,
          o_transmit_power_code} <= rx_byte[7:1];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_SIGNAL_STRENGTH_CONTROL)) begin
        {signal_reserved, o_signal_measure_enable} <= rx_byte[7:4];
      end
      if (write_hit(wr_single, cmd_addr, `ADDR_PIPE2_RECEIVE_ADDRESS_LOW)) begin
        o_pipe2_address_low <= rx_byte;
      end
    end
  end

  // ****************************************
  // multi-byte pipe addresses
  // ****************************************
  genvar lane;
  generate
    for (lane = 0; lane < 5; lane = lane + 1) begin : g_addr_lane
      always @(posedge i_core_clk or posedge i_reset) begin
        if (i_reset) begin
          o_pipe0_address[lane*8 +: 8] <= PIPE0_RESET[lane*8 +: 8];
          o_pipe1_address[lane*8 +: 8] <= PIPE1_RESET[lane*8 +: 8];
        end else if (wr_stb && data_cnt == lane) begin
          if (cmd_addr == `ADDR_PIPE0_RECEIVE_ADDRESS) begin
            o_pipe0_address[lane*8 +: 8] <= rx_byte;
          end
          if (cmd_addr == `ADDR_PIPE1_RECEIVE_ADDRESS) begin
            o_pipe1_address[lane*8 +: 8] <= rx_byte;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // event flags and counters
  // ****************************************
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      rx_ready_flag <= 1'b0;
      tx_done_flag <= 1'b0;
      retry_limit_flag <= 1'b0;
      pipe_number <= `RESET_PIPE_NUMBER;
      lost_packet_count <= 4'h0;
      retry_count <= 4'h0;
    end else begin
      rx_ready_flag <= i_rx_data_arrived |
        (rx_ready_flag & ~(flag_clear & rx_byte[`BIT_RX_READY]));
      tx_done_flag <= (o_pipe_autoack_enable[0] ? i_ack_received : i_tx_sent) |
        (tx_done_flag & ~(flag_clear & rx_byte[`BIT_TX_DONE]));
      retry_limit_flag <= i_retry_limit_hit |
        (retry_limit_flag & ~(flag_clear & rx_byte[`BIT_RETRY_LIMIT]));
      if (i_rx_data_arrived) begin
        pipe_number <= i_rx_pipe_number;
      end else if (i_rx_fifo_empty) begin
        pipe_number <= `RESET_PIPE_NUMBER;
      end
      if (write_hit(wr_stb, cmd_addr, `ADDR_CHANNEL_SELECT)) begin
        lost_packet_count <= 4'h0;
      end else if (i_packet_lost && lost_packet_count != `COUNT_SATURATE) begin
        lost_packet_count <= lost_packet_count + 4'h1;
      end
      if (i_new_packet_start) begin
        retry_count <= 4'h0;
      end else if (i_retransmit && retry_count != `COUNT_SATURATE) begin
        retry_count <= retry_count + 4'h1;
      end
    end
  end

  // ****************************************
  // retry wait timer
  // ****************************************
  // (code+1) steps of 250 us
  assign retry_wait_product = ({28'h000_0000, retry_delay_code} + 32'h0000_0001)
    * {14'h0000, RETRY_STEP_CYCLES};

  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      retry_timer <= 18'h0_0000;
      o_retry_wait_done <= 1'b0;
    end else begin
      o_retry_wait_done <= 1'b0;
      if (i_retry_wait_start && !retry_limit_flag) begin
        retry_timer <= retry_wait_product[17:0];
      end else if (retry_timer != 18'h0_0000) begin
        retry_timer <= retry_timer - 18'h0_0001;
        if (retry_timer == 18'h0_0001) begin
          o_retry_wait_done <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  always @(posedge i_core_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq_n <= 1'b1;
      o_crc_enable <= 1'b1;
      o_pseudo_random_test_enable <= 1'b0;
      o_transmit_hold <= 1'b0;
    end else begin
      o_irq_n <= ~((rx_ready_flag & ~rx_ready_irq_mask) |
        (tx_done_flag & ~tx_done_irq_mask) |
        (retry_limit_flag & ~retry_limit_irq_mask));
      o_crc_enable <= crc_effective;
      o_pseudo_random_test_enable <= pseudo_random_bit & o_carrier_test_enable;
      o_transmit_hold <= retry_limit_flag;
    end
  end
endmodule // radio_config_register_bank

// ==== tb/radio_cfg_sva.sv ====
`timescale 1ns/100ps
// ****************
// port checks
// ****************
module radio_cfg_sva (
  input wire i_core_clk,
  input wire i_reset,
  input wire i_csn,
  input wire i_retry_limit_hit,
  input wire o_miso_oe,
  input wire o_irq_n,
  input wire o_crc_enable,
  input wire [5:0] o_pipe_autoack_enable,
  input wire o_carrier_test_enable,
  input wire o_pseudo_random_test_enable,
  input wire o_transmit_hold,
  input wire o_retry_wait_done
);
  default clocking @(posedge i_core_clk);
  endclocking
  default disable iff (i_reset);
  property p_rst;
    $fell(i_reset) |-> o_irq_n && !o_miso_oe && !o_transmit_hold;
  endproperty
  property p_crc;
    |o_pipe_autoack_enable |=> o_crc_enable;
  endproperty
  property p_prbs;
    o_pseudo_random_test_enable |-> $past(o_carrier_test_enable);
  endproperty
  property p_hold;
    i_retry_limit_hit |=> ##1 o_transmit_hold;
  endproperty
  property p_done;
    o_retry_wait_done |=> !o_retry_wait_done;
  endproperty
  property p_oe_on;
    $fell(i_csn) |-> ##[1:4] o_miso_oe;
  endproperty
  property p_oe_off;
    $rose(i_csn) |-> ##[1:4] !o_miso_oe;
  endproperty
  property p_hold_fall;
    $fell(o_transmit_hold) |-> o_miso_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("bad state after reset");
  a_crc: assert property (p_crc) else $error("checksum not forced");
  a_prbs: assert property (p_prbs) else $error("stream without carrier");
  a_hold: assert property (p_hold) else $error("hold missing");
  a_done: assert property (p_done) else $error("wait done too long");
  a_oe_on: assert property (p_oe_on) else $error("miso not enabled");
  a_oe_off: assert property (p_oe_off) else $error("miso not released");
  a_hold_fall: assert property (p_hold_fall) else $error("hold fell outside frame");
  c_irq: cover property ($fell(o_irq_n));
  c_done: cover property (o_retry_wait_done);
  c_hold: cover property ($fell(o_transmit_hold));
endmodule // radio_cfg_sva
bind radio_config_register_bank radio_cfg_sva chk (.*);

// ==== tb/spi_host.sv ====
`timescale 1ns/100ps
// ****************
// host link master
// ****************
module spi_host (
  output logic o_csn,
  output logic o_sck,
  output logic o_mosi,
  input wire i_miso
);
  initial begin
    o_csn = 1;
    o_sck = 0;
    o_mosi = 0;
  end
  task xfer(input [7:0] cmd, input int n, input [39:0] wd, output [39:0] rd,
    output [7:0] st);
    logic [47:0] tx;
    logic [47:0] rx;
    tx = {wd, cmd};
    rx = '0;
    #7 o_csn = 0;
    for (int b = 0; b <= n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        o_mosi = tx[8*b+i];
        #80 o_sck = 1;
        #80 rx[8*b+i] = i_miso;
        o_sck = 0;
      end
    end
    #80 o_csn = 1;
    o_mosi = ~o_mosi;
    #93 st = rx[7:0];
    rd = rx[47:8];
  endtask
endmodule // spi_host

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
// ****************
// bench
// ****************
module testbench;
  logic i_core_clk, i_reset, i_rx_fifo_empty, i_tx_fifo_full;
  logic i_signal_threshold_one, i_signal_threshold_two;
  logic [2:0] i_rx_pipe_number;
  logic [7:0] ev, s;
  logic [39:0] r;
  logic [39:0] rv [0:13];
  int bad_count, checked, k;
  wire i_csn, i_sck, i_mosi, i_rx_data_arrived, i_tx_sent, i_ack_received;
  wire i_retry_limit_hit, i_packet_lost, i_retransmit, i_new_packet_start, i_retry_wait_start;
  wire o_miso, o_miso_oe, o_irq_n, o_power_up, o_primary_receiver, o_crc_enable;
  wire o_checksum_width_select, o_carrier_test_enable, o_pseudo_random_test_enable;
  wire o_rate_select_low, o_rate_select_high, o_transmit_attenuate, o_signal_measure_enable;
  wire o_transmit_hold, o_retry_wait_done;
  wire [5:0] o_pipe_autoack_enable, o_pipe_receive_enable;
  wire [3:0] o_retry_limit_code;
  wire [6:0] o_channel_number;
  wire [1:0] o_transmit_power_code;
  wire [39:0] o_pipe0_address, o_pipe1_address;
  wire [7:0] o_pipe2_address_low;
  assign {i_retry_wait_start, i_new_packet_start, i_retransmit, i_packet_lost,
    i_retry_limit_hit, i_ack_received, i_tx_sent, i_rx_data_arrived} = ev;
  radio_config_register_bank #(.RETRY_STEP_CYCLES(18'h4)) dut (.*);
  spi_host host (.o_csn(i_csn), .o_sck(i_sck), .o_mosi(i_mosi), .i_miso(o_miso));
  initial begin
    i_core_clk = 0;
    forever #10 i_core_clk = ~i_core_clk;
  end
  task chk(input [39:0] g, e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input [4:0] a, input int n, input [39:0] d);
    host.xfer({3'b001, a}, n, d, r, s);
  endtask
  task rd(input [4:0] a, input int n, input [39:0] e);
    host.xfer({3'b000, a}, n, 40'h0, r, s);
    chk(r, e);
  endtask
  task pulse(input [7:0] m);
    @(posedge i_core_clk) #2 ev = m;
    @(posedge i_core_clk) #2 ev = 8'h00;
  endtask
  task test_done;
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    i_reset = 1;
    ev = 8'h00;
    {i_rx_pipe_number, i_rx_fifo_empty, i_tx_fifo_full} = 5'h00;
    {i_signal_threshold_one, i_signal_threshold_two} = 2'h0;
    rv = '{40'h08, 40'h3F, 40'h3F, 40'h0F, 40'h03, 40'h02, 40'h02, 40'h0E, 40'h00,
      40'h00, 40'hE7_E7E7_E7E7, 40'hC2_C2C2_C2C2, 40'hC3, 40'h00};
    repeat (12) @(posedge i_core_clk);
    #2 i_reset = 0;
    repeat (4) @(posedge i_core_clk);
    for (int a = 0; a < 14; a++) begin
      rd(a[4:0], (a == 10 || a == 11) ? 5 : 1, rv[a]);
    end
    chk(s, 8'h0E);
    wr(5'h0A, 2, 40'h3412);
    rd(5'h0A, 5, 40'hE7_E7E7_3412);
    chk(o_pipe0_address, 40'hE7_E7E7_3412);
    wr(5'h0B, 5, 40'h01_0203_0405);
    chk(o_pipe1_address, 40'h01_0203_0405);
    wr(5'h0C, 1, 8'h5A);
    chk(o_pipe2_address_low, 8'h5A);
    for (k = 0; k < 4; k++) begin
      wr(5'h06, 1, {k[0], 1'b0, k[1], k[1:0], 1'b0});
      chk({o_rate_select_low, o_rate_select_high, o_transmit_power_code}, {k[0], k[1], k[1:0]});
    end
    wr(5'h06, 1, 8'hD0);
    chk({o_carrier_test_enable, o_pseudo_random_test_enable, o_transmit_attenuate}, 3'h7);
    wr(5'h06, 1, 8'h40);
    chk({o_carrier_test_enable, o_pseudo_random_test_enable}, 2'h0);
    wr(5'h01, 1, 8'h00);
    wr(5'h00, 1, 8'h07);
    chk({o_crc_enable, o_checksum_width_select, o_power_up, o_primary_receiver}, 4'h7);
    wr(5'h01, 1, 8'h01);
    rd(5'h00, 1, 8'h0F);
    wr(5'h02, 1, 8'h05);
    chk({o_pipe_autoack_enable, o_pipe_receive_enable}, 12'h045);
    wr(5'h04, 1, 8'hF5);
    chk(o_retry_limit_code, 4'h5);
    pulse(8'h80);
    for (k = 0; k < 200 && o_retry_wait_done !== 1'b1; k++) @(posedge i_core_clk) #2;
    chk(k, 64);
    @(posedge i_core_clk) #2 i_rx_pipe_number = 3'h3;
    pulse(8'h01);
    rd(5'h07, 1, 8'h46);
    chk(o_irq_n, 1'b0);
    wr(5'h07, 1, 8'h00);
    rd(5'h07, 1, 8'h46);
    wr(5'h07, 1, 8'h40);
    chk(o_irq_n, 1'b1);
    wr(5'h00, 1, 8'h4F);
    pulse(8'h01);
    @(posedge i_core_clk) #2;
    chk(o_irq_n, 1'b1);
    wr(5'h07, 1, 8'h40);
    pulse(8'h02);
    rd(5'h07, 1, 8'h06);
    pulse(8'h04);
    rd(5'h07, 1, 8'h26);
    wr(5'h07, 1, 8'h20);
    pulse(8'h08);
    rd(5'h07, 1, 8'h16);
    chk(o_transmit_hold, 1'b1);
    wr(5'h07, 1, 8'h10);
    chk({o_transmit_hold, o_irq_n}, 2'h1);
    @(posedge i_core_clk) #2 {i_rx_fifo_empty, i_tx_fifo_full} = 2'h3;
    rd(5'h07, 1, 8'h0F);
    repeat (16) pulse(8'h10);
    pulse(8'h20);
    pulse(8'h20);
    rd(5'h08, 1, 8'hF2);
    pulse(8'h60);
    rd(5'h08, 1, 8'hF0);
    wr(5'h05, 1, 8'h10);
    rd(5'h08, 1, 8'h00);
    chk(o_channel_number, 7'h10);
    @(posedge i_core_clk) #2 {i_signal_threshold_one, i_signal_threshold_two} = 2'h3;
    wr(5'h09, 1, 8'h1F);
    rd(5'h09, 1, 8'h13);
    chk(o_signal_measure_enable, 1'b1);
    test_done;
  end
endmodule // testbench
